// [dv/supervisor_device_model.sv]
// Purpose: Behavioural window supervisor seen from its pins.
// Assumes: Window and supply states arrive as clean levels.
// Notes:   Release delay is given in cycles by the bench.
`timescale 1ns/1ps
`default_nettype none
module supervisor_device_model
    import supervisor_host_pkg::*;
(
    // Clock.
    input  wire logic        ref_clk,
    // Conditions around the device.
    input  wire logic        supply_ok,
    input  wire logic        in_window,
    input  wire delay_mode_t strap,
    input  wire logic [15:0] dly,
    // Pins shared with the host.
    input  wire logic        mr_n,
    input  wire logic        pin_oe,
    input  wire logic        pin_out,
    output logic             pin_level,
    output logic             reset_n
);
    // Classification time of the delay pin, shortened like the bench's other delays.
    localparam logic [7:0] CLS = 8'h32;
    logic [7:0]  cls_r = CLS;      // Classification cycles still to run.
    logic [15:0] cnt_r = 16'h0000; // Release delay progress.
    logic        lat_r = 1'b0;     // Latch is holding reset low.
    logic        rst_r = 1'b0;     // Reset output with a valid supply.
    logic        junk_r = 1'b0;    // Changing level while the supply is too low.
    // A grounded strap reads low unless the host drives the pin.
    assign pin_level = pin_oe ? pin_out : (strap == MODE_PULLUP);
    // Below power-on level the output is meaningless, so it wanders.
    assign reset_n = supply_ok ? rst_r : junk_r;
    // Reset follows window, manual reset and latch, timed by the delay.
    always_ff @(posedge ref_clk) begin
        junk_r <= ~junk_r;
        if (!supply_ok) begin
            rst_r <= 1'b0;
            cnt_r <= 16'h0000;
            cls_r <= CLS;
            lat_r <= (strap == MODE_LATCH);
        end else if (lat_r) begin
            rst_r <= pin_level;
            lat_r <= !pin_level;
            // Unlatching skips any delay, so no classification is left pending.
            cls_r <= 8'h00;
        end else if (!in_window || !mr_n) begin
            rst_r <= 1'b0;
            cnt_r <= 16'h0000;
            lat_r <= (strap == MODE_LATCH);
            // Leaving the window means the next entry classifies the pin again.
            if (!in_window) begin
                cls_r <= CLS;
            end
        end else if (!rst_r) begin
            if (cls_r != 8'h00) begin
                // The release delay only starts once the pin is classified.
                cls_r <= cls_r - 8'h01;
            end else if (cnt_r >= dly) begin
                // Every strap's delay, variant D's fixed one included, arrives as dly.
                rst_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// [dv/supervisor_host_checker.sv]
// Purpose: Port-level checks of the supervisor host.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Bound to every supervisor_host instance.
`timescale 1ns/1ps
`default_nettype none
module supervisor_host_checker
    import supervisor_host_pkg::*;
(
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        reset,
    // Inputs of the host.
    input wire delay_mode_t delay_mode,
    input wire logic        supply_ok,
    input wire logic        dev_reset_n,
    input wire logic        force_reset_req,
    input wire logic        unlatch_req,
    // Outputs of the host.
    input wire logic        manual_reset_in_n,
    input wire logic        delay_select_pin_out,
    input wire logic        delay_select_pin_oe,
    input wire logic        target_in_reset,
    input wire logic        latched,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        req_ignored
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Counts the cycles the manual reset pin has been low.
    logic [7:0] low_cnt_r;
    // The count restarts whenever the pin is high.
    always_ff @(posedge ref_clk) begin
        if (reset || manual_reset_in_n) begin
            low_cnt_r <= 8'h00;
        end else begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end
    end
    // A manual reset request that the host has to take.
    sequence mr_take_s;
        force_reset_req && !busy && !done && supply_ok && dev_reset_n && !unlatch_req;
    endsequence
    // An unlatch request that the host has to take.
    sequence unlatch_take_s;
        unlatch_req && !busy && latched && supply_ok && delay_mode == MODE_LATCH;
    endsequence
    chk_mr_accept: assert property (mr_take_s |=> !manual_reset_in_n)
        else $error("manual reset pin did not fall after a request");
    chk_mr_width: assert property ($rose(manual_reset_in_n) |-> low_cnt_r == 8'h19)
        else $error("manual reset pulse was not 25 cycles long");
    chk_mr_refuse: assert property (force_reset_req && !dev_reset_n |=> req_ignored)
        else $error("request during reset was not refused");
    chk_target_low: assert property (!dev_reset_n |=> target_in_reset)
        else $error("target not shown in reset");
    chk_target_power: assert property (!supply_ok |=> target_in_reset)
        else $error("target not shown in reset while supply is low");
    chk_unlatch_drive: assert property (unlatch_take_s |=> delay_select_pin_oe && delay_select_pin_out)
        else $error("delay pin not driven high after unlatch request");
    chk_drive_latch: assert property (delay_select_pin_oe |-> delay_mode == MODE_LATCH)
        else $error("delay pin driven outside latch mode");
    chk_oe_drop: assert property (delay_select_pin_oe && $rose(dev_reset_n) |-> ##[1:2] !delay_select_pin_oe)
        else $error("delay pin still driven after release");
    chk_unlatch_done: assert property ($rose(delay_select_pin_oe) |-> ##[1:302] done)
        else $error("unlatch sequence did not finish");
endmodule
bind supervisor_host supervisor_host_checker supervisor_host_checker_i (.ref_clk, .reset,
    .delay_mode, .supply_ok, .dev_reset_n, .force_reset_req, .unlatch_req, .manual_reset_in_n,
    .delay_select_pin_out, .delay_select_pin_oe, .target_in_reset, .latched, .busy, .done,
    .req_ignored);
`default_nettype wire

// [dv/window_supervisor_reset_delay_tb.sv]
// Purpose: Self-checking bench of the supervisor host against a device model.
// Assumes: Shortened delays: float 100, pull-up 200, capacitor 50 to 150 cycles.
// Notes:   Inputs change on rising edges; outputs are read on falling edges.
`timescale 1ns/1ps
`default_nettype none
module window_supervisor_reset_delay_tb
    import supervisor_host_pkg::*;
;
    logic        ref_clk, reset, supply_ok, in_window, force_reset_req, unlatch_req;
    delay_mode_t delay_mode;
    logic [15:0] dly;
    logic        manual_reset_in_n, pin_level, pin_out, pin_oe, dev_reset_n, target_in_reset;
    logic        latched, busy, done, req_ignored, delay_early, delay_late;
    logic [31:0] measured_cyc;
    int          errors = 0, checks = 0, cyc = 0;
    supervisor_host #(.FLOAT_CYC(100), .PULLUP_CYC(200), .CAP_MIN_CYC(50),
        .CAP_MAX_CYC(150), .CLASS_CYC(50)) supervisor_host_i (.ref_clk, .reset,
        .delay_mode, .supply_ok, .dev_reset_n, .force_reset_req, .unlatch_req,
        .manual_reset_in_n, .delay_select_pin_in(pin_level), .delay_select_pin_out(pin_out),
        .delay_select_pin_oe(pin_oe), .target_in_reset, .latched, .busy, .done, .req_ignored,
        .delay_early, .delay_late, .measured_cyc);
    supervisor_device_model supervisor_device_model_i (.ref_clk, .supply_ok, .in_window,
        .strap(delay_mode), .dly, .mr_n(manual_reset_in_n), .pin_oe, .pin_out, .pin_level,
        .reset_n(dev_reset_n));
    // Free-running 25 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Compares one value and reports a difference.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Gives one request a single cycle and steps past the edge that takes it.
    task automatic pulse(input logic unl);
        @(posedge ref_clk);
        force_reset_req <= !unl;
        unlatch_req <= unl;
        @(posedge ref_clk);
        force_reset_req <= 1'b0;
        unlatch_req <= 1'b0;
        @(negedge ref_clk);
    endtask
    // Waits, bounded, for done or for the device release.
    task automatic wait_for(input logic want_done, input int lim);
        int k;
        k = 0;
        while ((want_done ? done : dev_reset_n) !== 1'b1 && k < lim) begin
            @(negedge ref_clk);
            k++;
        end
        check("wait", k < lim, 1'b1);
    endtask
    // Manual resets over the float, pull-up and capacitor options, with short, good and long delays.
    task automatic t_manual();
        delay_mode_t m [6] = '{MODE_FLOAT, MODE_FLOAT, MODE_FLOAT, MODE_PULLUP, MODE_CAP, MODE_CAP};
        logic [15:0] d [6] = '{16'h0064, 16'h0032, 16'h008C, 16'h00C8, 16'h0028, 16'h0064};
        logic [1:0]  f [6] = '{2'b00, 2'b10, 2'b01, 2'b00, 2'b10, 2'b00};
        for (int i = 0; i < 6; i++) begin
            wait_for(1'b0, 400);
            @(posedge ref_clk);
            delay_mode <= m[i];
            dly <= d[i];
            pulse(1'b0);
            check("mr_pin", manual_reset_in_n, 1'b0);
            // The device sees the pin low one edge later, and busy follows the state.
            @(negedge ref_clk);
            check("busy", busy, 1'b1);
            check("dev_reset", dev_reset_n, 1'b0);
            wait_for(1'b1, 600);
            check("early_late", {delay_early, delay_late}, f[i]);
            if (!f[i][0]) begin
                check("measured", measured_cyc >= d[i] && measured_cyc <= d[i] + 6, 1'b1);
            end
        end
    endtask
    // A request while the device holds reset is refused.
    task automatic t_refuse();
        wait_for(1'b0, 400);
        @(posedge ref_clk);
        in_window <= 1'b0;
        pulse(1'b0);
        check("ignored", req_ignored, 1'b1);
        check("mr_idle", manual_reset_in_n, 1'b1);
        check("target", target_in_reset, 1'b1);
        @(posedge ref_clk);
        in_window <= 1'b1;
        wait_for(1'b0, 400);
        @(negedge ref_clk);
        check("target", target_in_reset, 1'b0);
    endtask
    // Latch holds reset low until the host drives the pin high.
    task automatic t_latch();
        @(posedge ref_clk);
        delay_mode <= MODE_LATCH;
        @(posedge ref_clk);
        in_window <= 1'b0;
        @(posedge ref_clk);
        in_window <= 1'b1;
        repeat (150) @(negedge ref_clk);
        check("latched_low", dev_reset_n, 1'b0);
        check("latched", latched, 1'b1);
        pulse(1'b1);
        check("pin_drive", {pin_oe, pin_out}, 2'b11);
        wait_for(1'b1, 400);
        check("unlatched", dev_reset_n, 1'b1);
        check("late", delay_late, 1'b0);
        check("pin_free", pin_oe, 1'b0);
        @(posedge ref_clk);
        delay_mode <= MODE_FLOAT;
        pulse(1'b1);
        check("pin_free", pin_oe, 1'b0);
    endtask
    // Supply below power-on level: the reset pin is not trusted.
    task automatic t_supply();
        @(posedge ref_clk);
        supply_ok <= 1'b0;
        pulse(1'b0);
        check("ignored", req_ignored, 1'b1);
        check("target", target_in_reset, 1'b1);
        @(posedge ref_clk);
        supply_ok <= 1'b1;
        wait_for(1'b0, 400);
        @(negedge ref_clk);
        check("target", target_in_reset, 1'b0);
    endtask
    // Main sequence.
    initial begin
        reset = 1'b1;
        supply_ok = 1'b1;
        in_window = 1'b1;
        delay_mode = MODE_FLOAT;
        dly = 16'h0064;
        force_reset_req = 1'b0;
        unlatch_req = 1'b0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        @(negedge ref_clk);
        check("mr_idle", manual_reset_in_n, 1'b1);
        check("pin_idle", pin_oe, 1'b0);
        t_manual();
        t_refuse();
        t_latch();
        t_supply();
        end_sim();
    end
    // Cuts a hang short.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
endmodule
`default_nettype wire

// [verilog/delay_meter.sv]
// Purpose: Saturating cycle counter used to time reset release.
// Assumes: Clear has priority over run.
// Notes:   Holds its value when run is low.

`timescale 1ns/1ps
`default_nettype none

module delay_meter #(
    parameter int W = 32
) (
    // Clock and reset.
    input  wire logic         ref_clk,
    input  wire logic         reset,
    // Control.
    input  wire logic         clear,
    input  wire logic         run,
    // Elapsed cycles.
    output logic [W-1:0]      count
);

    // Count up while running, stopping at the top value.
    always_ff @(posedge ref_clk) begin
        if (reset || clear) begin
            count <= '0;
        end else if (run && (count != {W{1'b1}})) begin
            count <= count + 1'b1;
        end
    end

endmodule

`default_nettype wire

// [verilog/supervisor_host.sv]
// Purpose: Host controller that drives a window supervisor's manual reset and delay pin.
// Assumes: Supervisor reset output and supply status are synchronous to ref_clk.
// Notes:   Times the release delay after a manual reset and clears latch mode.

`timescale 1ns/1ps
`default_nettype none

module supervisor_host
    import supervisor_host_pkg::*;
#(
    parameter variant_t VARIANT     = VAR_A,
    parameter int       CAP_NF      = 1,
    parameter int       TOL_PCT     = FIXED_TOL_PCT,
    parameter int       FLOAT_CYC   = float_cyc(VARIANT),
    parameter int       PULLUP_CYC  = pullup_cyc(VARIANT),
    parameter int       CAP_MIN_CYC = cap_min_cyc(CAP_NF),
    parameter int       CAP_MAX_CYC = cap_max_cyc(CAP_NF),
    parameter int       CLASS_CYC   = CLASSIFY_CYC
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Board configuration of the delay pin.
    input  wire delay_mode_t delay_mode,
    // Supervisor status as seen by the host.
    input  wire logic        supply_ok,
    input  wire logic        dev_reset_n,
    // User requests, one-cycle pulses.
    input  wire logic        force_reset_req,
    input  wire logic        unlatch_req,
    // Manual reset pin toward the supervisor.
    output logic             manual_reset_in_n,
    // Delay pin: input, output and output enable.
    input  wire logic        delay_select_pin_in,
    output logic             delay_select_pin_out,
    output logic             delay_select_pin_oe,
    // Status toward the user.
    output logic             target_in_reset,
    output logic             latched,
    output logic             busy,
    output logic             done,
    output logic             req_ignored,
    output logic             delay_early,
    output logic             delay_late,
    output logic [CNT_W-1:0] measured_cyc
);

    // Host sequencing states.
    typedef enum {ST_IDLE, ST_MR_LOW, ST_MR_WAIT, ST_UNLATCH, ST_UNL_WAIT} state_t;

    // Tolerance window around the fixed delays.
    localparam int FLOAT_MIN  = (FLOAT_CYC * (100 - TOL_PCT) + 99) / 100;
    localparam int FLOAT_MAX  = (FLOAT_CYC * (100 + TOL_PCT)) / 100;
    localparam int PULLUP_MIN = (PULLUP_CYC * (100 - TOL_PCT) + 99) / 100;
    localparam int PULLUP_MAX = (PULLUP_CYC * (100 + TOL_PCT)) / 100;

    state_t           state_r;      // Current sequencing state.
    logic [CNT_W-1:0] elapsed;      // Cycles since the sequence left idle.
    logic             meter_clear;  // Restarts the meter.
    logic             meter_run;    // Lets the meter count.
    logic             dev_low;      // Reset seen low with a trustworthy supply.
    logic [CNT_W-1:0] exp_min;      // Shortest acceptable release delay.
    logic [CNT_W-1:0] exp_max;      // Longest acceptable release delay.
    logic             latch_mode;   // The board grounds the delay pin.

    // The reset value is meaningless until the supply is trusted.
    assign dev_low    = supply_ok && !dev_reset_n;
    assign latch_mode = (delay_mode == MODE_LATCH);

    // Select the expected release window from variant and pin strapping.
    always_comb begin
        exp_min = CNT_W'(FLOAT_MIN);
        exp_max = CNT_W'(FLOAT_MAX);
        if (delay_mode == MODE_PULLUP) begin
            exp_min = CNT_W'(PULLUP_MIN);
            exp_max = CNT_W'(PULLUP_MAX);
        end else if (delay_mode == MODE_CAP) begin
            if (VARIANT == VAR_D) begin
                // This variant has no capacitor option and keeps its fixed delay.
                exp_min = CNT_W'(FLOAT_MIN);
                exp_max = CNT_W'(FLOAT_MAX);
            end else begin
                exp_min = CNT_W'(CAP_MIN_CYC);
                exp_max = CNT_W'(CAP_MAX_CYC);
            end
        end
    end

    // The meter is held clear in idle and runs through a whole sequence.
    assign meter_clear = (state_r == ST_IDLE);
    assign meter_run   = (state_r != ST_IDLE);

    // Release-delay timer.
    delay_meter #(
        .W (CNT_W)
    ) delay_meter_i (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clear   (meter_clear),
        .run     (meter_run),
        .count   (elapsed)
    );

    // Sequencing of manual reset and unlatch.
    always_ff @(posedge ref_clk) begin
        if (reset || !supply_ok) begin
            // Below trusted supply nothing the device says is acted on.
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (unlatch_req && latched && latch_mode) begin
                        state_r <= ST_UNLATCH;
                    end else if (force_reset_req && !dev_low) begin
                        state_r <= ST_MR_LOW;
                    end
                end
                ST_MR_LOW: begin
                    if (elapsed >= CNT_W'(MR_PULSE_CYC - 1)) begin
                        state_r <= ST_MR_WAIT;
                    end
                end
                ST_MR_WAIT: begin
                    // Latch mode never releases; the latch is recorded instead.
                    if (!dev_low || latch_mode) begin
                        state_r <= ST_IDLE;
                    end else if (elapsed >= exp_max + CNT_W'(MR_PULSE_CYC)) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_UNLATCH: begin
                    if (!dev_low || elapsed >= CNT_W'(UNLATCH_CYC - 1)) begin
                        state_r <= ST_UNL_WAIT;
                    end
                end
                ST_UNL_WAIT: begin
                    if (!dev_low || elapsed >= CNT_W'(UNLATCH_CYC + UNLATCH_RESP_CYC)) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Manual reset pin is low only during the pulse.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            manual_reset_in_n <= 1'b1;
        end else begin
            manual_reset_in_n <= !(state_r == ST_IDLE && force_reset_req && !dev_low
                                   && supply_ok && !(unlatch_req && latched && latch_mode))
                                 && !(state_r == ST_MR_LOW
                                      && elapsed < CNT_W'(MR_PULSE_CYC - 1));
        end
    end

    // Delay pin is driven high only to clear a latch, never in other modes.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            delay_select_pin_out <= 1'b0;
            delay_select_pin_oe  <= 1'b0;
        end else begin
            delay_select_pin_out <= 1'b1;
            delay_select_pin_oe  <= supply_ok && latch_mode
                                    && ((state_r == ST_IDLE && unlatch_req && latched)
                                        || (state_r == ST_UNLATCH && dev_low
                                            && elapsed < CNT_W'(UNLATCH_CYC - 1)));
        end
    end

    // Qualified reset and latch status.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            target_in_reset <= 1'b1;
            latched         <= 1'b0;
        end else begin
            target_in_reset <= !supply_ok || !dev_reset_n;
            if (!supply_ok || !latch_mode || !dev_low) begin
                latched <= 1'b0;
            end else begin
                // A low reset in latch mode is held until unlatched.
                latched <= 1'b1;
            end
        end
    end

    // Busy flag and refusal report.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy        <= 1'b0;
            req_ignored <= 1'b0;
        end else begin
            busy        <= (state_r != ST_IDLE);
            // A manual reset while reset is already low would be ignored by the device.
            req_ignored <= (state_r != ST_IDLE || dev_low || !supply_ok)
                           && force_reset_req;
        end
    end

    // Completion, measured delay and timing verdicts.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            done         <= 1'b0;
            delay_early  <= 1'b0;
            delay_late   <= 1'b0;
            measured_cyc <= '0;
        end else begin
            done <= 1'b0;
            if (supply_ok && state_r == ST_MR_WAIT && !latch_mode) begin
                if (!dev_low) begin
                    // Delay counted from the manual reset pin's return high.
                    done         <= 1'b1;
                    measured_cyc <= elapsed - CNT_W'(MR_PULSE_CYC);
                    delay_early  <= (elapsed - CNT_W'(MR_PULSE_CYC)) < exp_min;
                    delay_late   <= 1'b0;
                end else if (elapsed >= exp_max + CNT_W'(MR_PULSE_CYC)) begin
                    done         <= 1'b1;
                    measured_cyc <= elapsed - CNT_W'(MR_PULSE_CYC);
                    delay_early  <= 1'b0;
                    delay_late   <= 1'b1;
                end
            end else if (supply_ok && state_r == ST_MR_WAIT) begin
                done         <= 1'b1;
                measured_cyc <= '0;
                delay_early  <= 1'b0;
                delay_late   <= 1'b0;
            end else if (supply_ok && state_r == ST_UNL_WAIT) begin
                if (!dev_low
                    || elapsed >= CNT_W'(UNLATCH_CYC + UNLATCH_RESP_CYC)) begin
                    done         <= 1'b1;
                    measured_cyc <= elapsed;
                    delay_early  <= 1'b0;
                    delay_late   <= dev_low;
                end
            end
        end
    end

endmodule

`default_nettype wire

// [verilog/supervisor_host_pkg.sv]
// Purpose: Shared constants and types for the host that drives a window supervisor.
// Assumes: 25 MHz reference clock; all supervisor pins arrive synchronous to it.
// Notes:   Times are kept in their own units; cycle counts are derived from them.

package supervisor_host_pkg;

    // Reference clock rate in MHz.
    localparam int CLK_MHZ        = 25;

    // Time the supervisor spends classifying its delay pin, in microseconds.
    localparam int CLASSIFY_US    = 450;
    localparam int CLASSIFY_CYC   = CLASSIFY_US * CLK_MHZ;

    // Width of a manual reset pulse the host produces, in microseconds.
    localparam int MR_PULSE_US    = 1;
    localparam int MR_PULSE_CYC   = MR_PULSE_US * CLK_MHZ;

    // Time the delay pin is driven high to clear a latch, in microseconds.
    localparam int UNLATCH_US     = 10;
    localparam int UNLATCH_CYC    = UNLATCH_US * CLK_MHZ;

    // Longest wait for the release after unlatching, in microseconds.
    localparam int UNLATCH_RESP_US  = 2;
    localparam int UNLATCH_RESP_CYC = UNLATCH_RESP_US * CLK_MHZ;

    // Fixed release delays in microseconds, per variant.
    localparam int A_FLOAT_US     = 10000;
    localparam int A_PULLUP_US    = 200000;
    localparam int B_FLOAT_US     = 1000;
    localparam int B_PULLUP_US    = 20000;
    localparam int C_FLOAT_US     = 5000;
    localparam int C_PULLUP_US    = 100000;
    localparam int D_FIXED_US     = 50;

    // Capacitor delay lines in tenths of a microsecond: slope per nF and offset.
    localparam longint CAP_MIN_SLOPE  = 27427;
    localparam longint CAP_MIN_OFFSET = 3000;
    localparam longint CAP_MAX_SLOPE  = 34636;
    localparam longint CAP_MAX_OFFSET = 7000;
    localparam longint TENTHS_PER_US  = 10;

    // Default tolerance applied to the fixed delays, in percent.
    localparam int FIXED_TOL_PCT  = 20;

    // Counter width for all timing.
    localparam int CNT_W          = 32;

    // Supervisor variant.
    typedef enum {VAR_A, VAR_B, VAR_C, VAR_D} variant_t;

    // How the board connects the delay pin.
    typedef enum logic [1:0] {MODE_FLOAT, MODE_PULLUP, MODE_CAP, MODE_LATCH} delay_mode_t;

    // Release delay in cycles with the delay pin floating.
    function automatic int float_cyc(variant_t v);
        case (v)
            VAR_A:   return A_FLOAT_US * CLK_MHZ;
            VAR_B:   return B_FLOAT_US * CLK_MHZ;
            VAR_C:   return C_FLOAT_US * CLK_MHZ;
            default: return D_FIXED_US * CLK_MHZ;
        endcase
    endfunction

    // Release delay in cycles with the delay pin pulled up.
    function automatic int pullup_cyc(variant_t v);
        case (v)
            VAR_A:   return A_PULLUP_US * CLK_MHZ;
            VAR_B:   return B_PULLUP_US * CLK_MHZ;
            VAR_C:   return C_PULLUP_US * CLK_MHZ;
            default: return D_FIXED_US * CLK_MHZ;
        endcase
    endfunction

    // Shortest capacitor delay in cycles, rounded up.
    function automatic int cap_min_cyc(int cap_nf);
        longint t;
        t = CAP_MIN_SLOPE * cap_nf + CAP_MIN_OFFSET;
        return int'((t * CLK_MHZ + TENTHS_PER_US - 1) / TENTHS_PER_US);
    endfunction

    // Longest capacitor delay in cycles, rounded down.
    function automatic int cap_max_cyc(int cap_nf);
        longint t;
        t = CAP_MAX_SLOPE * cap_nf + CAP_MAX_OFFSET;
        return int'((t * CLK_MHZ) / TENTHS_PER_US);
    endfunction

endpackage
